/* core/roc_top.v */
/*
 * Relay output controller: twelve relay outputs with back-indication
 * checking, module inhibit, fail values, mask, freeze, test access,
 * sleep, failure status and a masked interrupt.
 * Assumes a single-clock register master (plain strobes, read data one
 * cycle later); relay contacts, selector switch, inhibit supply, variant
 * strap and fault detector are asynchronous pins.
 */
// How it works
// R1: twelve independent relay drive outputs follow their commanded states.
// R2: energized variant drives every relay off on module fault.
// R3: latched variant holds each relay position through module fault.
// R4: back indication compared to command; mismatch readable and signalled.
// R5: mismatch reporting suppressed while relays are inhibited.
// R6: inhibit enabled and supply open forces energized relays to zero.
// R7: latched relays ignore the inhibit and stay controllable.
// R8: current inhibit status readable by software.
// R9: selector decode: 00/01 enabled, 10 software, 11 disabled.
// R10: software mode takes inhibit enable from a control bit, default off.
// R11: inhibited energized relays ignore commands until supply returns.
// R12: per-output fail value, keep-last or predefined, on stop or comm loss.
// R13: per-output mask forces the predefined value in normal operation.
// R14: optional startup reset drives latched relays to zero until run.
// R15: sleep command stops all function and asserts low-power output.
// R16: module failure lights error indicator and shows readable status.
// R17: freeze holds every output at its value when frozen.
// R18: test access reports configuration, actual outputs, sets outputs.
// R19: mismatch check waits for relay settle time after every change.
`timescale 1ns/1ns
`include "roc_consts.vh"

module roc_top #(
    parameter N = 12,
    parameter CW = 24,
    parameter SETTLE_CYC = `ROC_SETTLE_CYC,
    parameter WDOG_CYC = `ROC_WDOG_CYC
) (
    input wire ref_clk,
    input wire rst,
    input wire [`ROC_AW-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire [N-1:0] back_ind,
    input wire sel_sw1,
    input wire sel_sw2,
    input wire inhibit_supply_line,
    input wire latched_strap,
    input wire module_fault,
    output wire [N-1:0] relay_drive,
    output wire err_led,
    output wire low_power,
    output wire irq
);

    // ==========================================================
    // input synchronisers
    localparam SW = N + 5;
    wire [SW-1:0] async_in;
    wire [SW-1:0] sync_s;

    // back indication shares the chain with the control pins, so every
    // decision sees one snapshot of the outside world
    assign async_in = {module_fault, latched_strap, inhibit_supply_line,
                       sel_sw2, sel_sw1, back_ind};

    roc_sync #(
        .W(SW)
    ) u_roc_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .d(async_in),
        .q(sync_s)
    );

    wire [N-1:0] back_s = sync_s[N-1:0];
    wire sw1_s = sync_s[N];
    wire sw2_s = sync_s[N+1];
    wire supply_s = sync_s[N+2];
    wire latched_s = sync_s[N+3];
    wire fault_s = sync_s[N+4];

    // ==========================================================
    // software registers
    reg [N-1:0] cmd_q;
    reg [`ROC_CTRL_W-1:0] ctrl_q;
    reg [N-1:0] failsel_q;
    reg [N-1:0] predef_q;
    reg [N-1:0] mask_q;
    reg [N-1:0] testval_q;
    reg [`ROC_IRQ_W-1:0] irq_stat_q;
    reg [`ROC_IRQ_W-1:0] irq_stat_d;
    reg [`ROC_IRQ_W-1:0] irq_mask_q;

    wire wr_cmd = reg_wr && (reg_addr == `ROC_OFS_CMD);
    wire wr_ctrl = reg_wr && (reg_addr == `ROC_OFS_CTRL);
    wire wr_fsel = reg_wr && (reg_addr == `ROC_OFS_FAILSEL);
    wire wr_pdef = reg_wr && (reg_addr == `ROC_OFS_PREDEF);
    wire wr_mask = reg_wr && (reg_addr == `ROC_OFS_MASK);
    wire wr_test = reg_wr && (reg_addr == `ROC_OFS_TESTVAL);
    wire wr_istat = reg_wr && (reg_addr == `ROC_OFS_IRQ_STAT);
    wire wr_imask = reg_wr && (reg_addr == `ROC_OFS_IRQ_MASK);

    wire run = ctrl_q[`ROC_CTRL_RUN];
    wire sleep = ctrl_q[`ROC_CTRL_SLEEP];
    wire freeze = ctrl_q[`ROC_CTRL_FREEZE];
    wire test = ctrl_q[`ROC_CTRL_TEST];
    wire sw_inh = ctrl_q[`ROC_CTRL_SW_INH];
    wire start_rst = ctrl_q[`ROC_CTRL_STARTRST];

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_q <= {N{1'b0}};
            ctrl_q <= `ROC_CTRL_RST;
            failsel_q <= {N{1'b0}};
            predef_q <= {N{1'b0}};
            mask_q <= {N{1'b0}};
            testval_q <= {N{1'b0}};
            irq_mask_q <= {`ROC_IRQ_W{1'b0}};
        end else begin
            if (wr_cmd)
                cmd_q <= reg_wdata[N-1:0];
            if (wr_ctrl)
                ctrl_q <= reg_wdata[`ROC_CTRL_W-1:0];
            if (wr_fsel)
                failsel_q <= reg_wdata[N-1:0];
            if (wr_pdef)
                predef_q <= reg_wdata[N-1:0];
            if (wr_mask)
                mask_q <= reg_wdata[N-1:0];
            if (wr_test)
                testval_q <= reg_wdata[N-1:0];
            if (wr_imask)
                irq_mask_q <= reg_wdata[`ROC_IRQ_W-1:0];
        end
    end

    // ==========================================================
    // communication watchdog
    // any register access proves the processor is alive; a runaway
    // program that keeps polling still counts as alive
    localparam [CW-1:0] WDOG_LOAD = WDOG_CYC[CW-1:0];
    reg [CW-1:0] wdog_q;
    wire comm_lost = (wdog_q == {CW{1'b0}});

    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            wdog_q <= {CW{1'b0}};
        else if (reg_wr || reg_rd)
            wdog_q <= WDOG_LOAD;
        else if (!comm_lost)
            wdog_q <= wdog_q - {{(CW-1){1'b0}}, 1'b1};
    end

    // ==========================================================
    // inhibit decode
    // R9: selector decode
    wire sw_mode = sw1_s && !sw2_s;
    // R10: software enable
    wire inh_en = !sw1_s || (sw_mode && sw_inh);
    // R6: open supply inhibits
    // R7: latched exempt
    wire inhibited = inh_en && !supply_s && !latched_s;

    // ==========================================================
    // start-up guard
    // the synchronisers clear to zero, so the decoded inhibit state is
    // wrong for the first edges after reset; its change event waits
    // until settled pins have reached the edge detector
    reg [1:0] boot_q;
    wire booted = (boot_q == 2'b11);

    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            boot_q <= 2'b00;
        else if (!booted)
            boot_q <= boot_q + 2'b01;
    end

    // ==========================================================
    // startup reset window
    // closes at the first run so a later restart cannot reset latches
    reg start_done_q;

    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            start_done_q <= 1'b0;
        else if (run)
            start_done_q <= 1'b1;
    end

    // ==========================================================
    // relay drive
    reg [N-1:0] relay_q;
    reg [N-1:0] relay_d;

    // priority, highest first: sleep, fault, inhibit, freeze, test,
    // startup reset, fail value, then mask over command; sleep sits on
    // top because a module that is not functioning moves nothing
    always @* begin
        relay_d = relay_q;
        if (sleep) begin
            // R15: sleep stops
            relay_d = relay_q;
        end else if (fault_s) begin
            // R2: energized off
            // R3: latched holds
            relay_d = latched_s ? relay_q : {N{1'b0}};
        end else if (inhibited) begin
            // R11: ignore commands
            relay_d = {N{1'b0}};
        end else if (freeze) begin
            // R17: freeze holds
            relay_d = relay_q;
        end else if (test) begin
            // R18: direct set
            relay_d = testval_q;
        end else if (!start_done_q && start_rst && latched_s) begin
            // R14: startup reset
            relay_d = {N{1'b0}};
        end else if (!run || comm_lost) begin
            // R12: fail value
            relay_d = (failsel_q & predef_q) | (~failsel_q & relay_q);
        end else begin
            // R13: mask forces
            // R1: follow command
            relay_d = (mask_q & predef_q) | (~mask_q & cmd_q);
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            relay_q <= {N{1'b0}};
        else
            relay_q <= relay_d;
    end

    assign relay_drive = relay_q;

    // ==========================================================
    // back indication check
    // one shared settle timer: a change on any relay delays all checks,
    // trading per-relay precision for eleven fewer counters
    // starts full, so nothing is reported before the first settle time
    localparam [CW-1:0] SETTLE_LOAD = SETTLE_CYC[CW-1:0];
    reg [CW-1:0] settle_q;
    reg [N-1:0] mism_q;
    wire settled = (settle_q == {CW{1'b0}});

    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            settle_q <= SETTLE_LOAD;
        else if (relay_d != relay_q)
            // R19: restart settle
            settle_q <= SETTLE_LOAD;
        else if (!settled)
            settle_q <= settle_q - {{(CW-1){1'b0}}, 1'b1};
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            mism_q <= {N{1'b0}};
        else if (settled && !inhibited && !sleep)
            // R4: compare position
            mism_q <= relay_q ^ back_s;
        else
            // R5: suppress when inhibited
            mism_q <= {N{1'b0}};
    end

    // ==========================================================
    // events and interrupt
    reg inhibited_q;
    reg fault_q;
    reg comm_lost_q;
    wire [`ROC_IRQ_W-1:0] events;

    assign events = {comm_lost && !comm_lost_q,
                     fault_s && !fault_q,
                     booted && (inhibited != inhibited_q),
                     |mism_q};

    always @* begin
        irq_stat_d = irq_stat_q;
        if (wr_istat)
            irq_stat_d = irq_stat_d & ~reg_wdata[`ROC_IRQ_W-1:0];
        // set wins over a clear in the same cycle
        irq_stat_d = irq_stat_d | events;
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inhibited_q <= 1'b0;
            fault_q <= 1'b0;
            // comm loss is the reset state, not an event
            comm_lost_q <= 1'b1;
            irq_stat_q <= {`ROC_IRQ_W{1'b0}};
        end else begin
            inhibited_q <= inhibited;
            fault_q <= fault_s;
            comm_lost_q <= comm_lost;
            irq_stat_q <= irq_stat_d;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);
    // R16: error indicator
    assign err_led = fault_q;
    assign low_power = sleep;

    // ==========================================================
    // read port
    wire [`ROC_INFO_W-1:0] info;
    // R8: inhibit status
    // R16: failure status
    assign info = {sleep, latched_s, comm_lost, fault_q,
                   sw_mode, inh_en, inhibited};

    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            reg_rdata <= 32'h0;
        else if (reg_rd) begin
            case (reg_addr)
                `ROC_OFS_CMD: reg_rdata <= {{(32-N){1'b0}}, cmd_q};
                `ROC_OFS_CTRL:
                    reg_rdata <= {{(32-`ROC_CTRL_W){1'b0}}, ctrl_q};
                `ROC_OFS_FAILSEL: reg_rdata <= {{(32-N){1'b0}}, failsel_q};
                `ROC_OFS_PREDEF: reg_rdata <= {{(32-N){1'b0}}, predef_q};
                `ROC_OFS_MASK: reg_rdata <= {{(32-N){1'b0}}, mask_q};
                `ROC_OFS_TESTVAL: reg_rdata <= {{(32-N){1'b0}}, testval_q};
                // R18: actual outputs
                `ROC_OFS_ACTUAL: reg_rdata <= {{(32-N){1'b0}}, relay_q};
                `ROC_OFS_MISMATCH: reg_rdata <= {{(32-N){1'b0}}, mism_q};
                `ROC_OFS_INFO:
                    reg_rdata <= {{(32-`ROC_INFO_W){1'b0}}, info};
                `ROC_OFS_IRQ_STAT:
                    reg_rdata <= {{(32-`ROC_IRQ_W){1'b0}}, irq_stat_q};
                `ROC_OFS_IRQ_MASK:
                    reg_rdata <= {{(32-`ROC_IRQ_W){1'b0}}, irq_mask_q};
                default: reg_rdata <= 32'h0;
            endcase
        end else
            reg_rdata <= 32'h0;
    end

endmodule

// ==========================================================
// two-flop synchroniser
// clears to zero: a pin that idles high reads low for two edges after
// reset, which the start-up guard above allows for
module roc_sync #(
    parameter W = 1
) (
    input wire ref_clk,
    input wire rst,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] meta_q;
    reg [W-1:0] stab_q;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_q <= {W{1'b0}};
            stab_q <= {W{1'b0}};
        end else begin
            meta_q <= d;
            stab_q <= meta_q;
        end
    end

    assign q = stab_q;

endmodule

/* core/roc_consts.vh */
/*
 * Constants of the relay output controller: register offsets, field
 * positions, reset values and timing figures.
 * Assumes byte addresses on the plain register port, one word each.
 */
`ifndef ROC_CONSTS_VH
`define ROC_CONSTS_VH

// ==========================================================
// register offsets
`define ROC_AW 8
`define ROC_OFS_CMD 8'h00
`define ROC_OFS_CTRL 8'h04
`define ROC_OFS_FAILSEL 8'h08
`define ROC_OFS_PREDEF 8'h0c
`define ROC_OFS_MASK 8'h10
`define ROC_OFS_TESTVAL 8'h14
`define ROC_OFS_ACTUAL 8'h18
`define ROC_OFS_MISMATCH 8'h1c
`define ROC_OFS_INFO 8'h20
`define ROC_OFS_IRQ_STAT 8'h24
`define ROC_OFS_IRQ_MASK 8'h28

// ==========================================================
// control register fields
`define ROC_CTRL_RUN 0
`define ROC_CTRL_SLEEP 1
`define ROC_CTRL_FREEZE 2
`define ROC_CTRL_TEST 3
`define ROC_CTRL_SW_INH 4
`define ROC_CTRL_STARTRST 5
`define ROC_CTRL_W 6
`define ROC_CTRL_RST 6'h00

// ==========================================================
// info register fields
`define ROC_INFO_INHIBITED 0
`define ROC_INFO_INH_EN 1
`define ROC_INFO_SW_MODE 2
`define ROC_INFO_FAILED 3
`define ROC_INFO_COMM_LOST 4
`define ROC_INFO_LATCHED 5
`define ROC_INFO_SLEEP 6
`define ROC_INFO_W 7

// ==========================================================
// interrupt status / mask fields
`define ROC_IRQ_MISMATCH 0
`define ROC_IRQ_INHIBIT 1
`define ROC_IRQ_FAIL 2
`define ROC_IRQ_COMM 3
`define ROC_IRQ_W 4

// ==========================================================
// timing: clock rate and times in their own units
`define ROC_CLK_KHZ 10000
`define ROC_SETTLE_MS 10
`define ROC_WDOG_MS 100
`define ROC_SETTLE_CYC (`ROC_SETTLE_MS * `ROC_CLK_KHZ)
`define ROC_WDOG_CYC (`ROC_WDOG_MS * `ROC_CLK_KHZ)

`endif

/* tb/roc_relay_model.sv */
/* relay contact model: back indication follows the drive after travel.
   assumes one clock; flip bits invert a contact to fake a stuck relay. */
`timescale 1ns/1ns
module roc_relay_model (
    input wire ref_clk,
    input wire [11:0] relay_drive,
    input wire [11:0] flip,
    output wire [11:0] back_ind
);
    reg [11:0] trav1_q = 12'h000;
    reg [11:0] trav2_q = 12'h000;
    // ==========================================
    // contact travel
    // two cycles of travel, far below the settle time
    always @(posedge ref_clk) begin
        trav1_q <= relay_drive;
        trav2_q <= trav1_q;
    end
    assign back_ind = trav2_q ^ flip;
endmodule

/* tb/roc_monitor.sv */
/* checker for the relay output controller ports.
   assumes binding into roc_top, one clock, rst active high. */
`timescale 1ns/1ns
`include "roc_consts.vh"
module roc_monitor #(
    parameter N = 12
) (
    input wire ref_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire sel_sw1,
    input wire inhibit_supply_line,
    input wire latched_strap,
    input wire module_fault,
    input wire [N-1:0] relay_drive,
    input wire err_led,
    input wire low_power,
    input wire irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire ctl_wr = reg_wr && reg_addr == `ROC_OFS_CTRL;
    // ==========================================
    // assertions
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 0)
        else $error("read data outside its cycle");
    irq_mask_a: assert property (reg_wr && reg_addr == `ROC_OFS_IRQ_MASK
        && reg_wdata[3:0] == 4'h0 |-> ##[1:2] !irq)
        else $error("irq high with all masked");
    sleep_power_a: assert property (ctl_wr && reg_wdata[1]
        |-> ##[1:2] low_power) else $error("sleep not entered");
    sleep_hold_a: assert property (low_power && $past(low_power)
        && $past(low_power, 2) |-> $stable(relay_drive))
        else $error("relay moved in sleep");
    fault_ee_a: assert property ((module_fault && !latched_strap
        && !low_power)[*4] |-> relay_drive == 0)
        else $error("energized relay on in fault");
    fault_latch_a: assert property ((module_fault && latched_strap
        && !low_power)[*4] |-> $stable(relay_drive))
        else $error("latched relay moved in fault");
    err_led_a: assert property (module_fault[*3] |=> err_led)
        else $error("error led not lit");
    inh_zero_a: assert property ((!sel_sw1 && !inhibit_supply_line
        && !latched_strap && !module_fault && !low_power)[*4]
        |-> relay_drive == 0) else $error("inhibited relay on");
    cover property (module_fault[*4]);
    cover property ((!inhibit_supply_line && !sel_sw1)[*4]);
    cover property (low_power[*3]);
endmodule
bind roc_top roc_monitor #(.N(N)) u_roc_monitor (.ref_clk(ref_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sel_sw1(sel_sw1), .inhibit_supply_line(inhibit_supply_line),
    .latched_strap(latched_strap), .module_fault(module_fault),
    .relay_drive(relay_drive), .err_led(err_led),
    .low_power(low_power), .irq(irq));

/* tb/tb_roc_top.sv */
/* register-level bench of the relay output controller.
   assumes short settle and comm-loss counts; gaps stay under 50 except the w(60) that forces comm loss. */
`timescale 1ns/1ns
`include "roc_consts.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_roc_top;
    reg ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0, v;
    reg sel_sw1 = 1, sel_sw2 = 1, sup = 1, latched_strap = 0, fault = 0;
    reg [11:0] flip = 12'h000, ex;
    wire [31:0] reg_rdata;
    wire [11:0] back_ind, relay_drive;
    wire err_led, low_power, irq;
    integer n_mismatch = 0, cmp_count = 0, i;
    reg [3:0] tbl [0:4];
    roc_top #(.SETTLE_CYC(20), .WDOG_CYC(50)) u_roc_top (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .back_ind(back_ind), .sel_sw1(sel_sw1),
        .sel_sw2(sel_sw2), .inhibit_supply_line(sup),
        .latched_strap(latched_strap), .module_fault(fault),
        .relay_drive(relay_drive), .err_led(err_led),
        .low_power(low_power), .irq(irq));
    roc_relay_model u_roc_relay_model (.ref_clk(ref_clk),
        .relay_drive(relay_drive), .flip(flip), .back_ind(back_ind));
    initial forever #50 ref_clk = ~ref_clk;
    task wr(input [7:0] a, input [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask
    task rd(input [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a; reg_rd <= 1;
        @(posedge ref_clk);
        reg_rd <= 0;
        #1 v = reg_rdata;
    endtask
    task w(input integer n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        // sw1 sw2 ctrl-bit4 expected-inhibit
        tbl[0] = 4'b0011; tbl[1] = 4'b0111; tbl[2] = 4'b1011;
        tbl[3] = 4'b1000; tbl[4] = 4'b1110;
        repeat (6) @(posedge ref_clk);
        rst <= 0;
        rd(`ROC_OFS_CTRL); `CHK("ctrl", 32'h0, v)
        wr(`ROC_OFS_IRQ_STAT, 32'hf);
        wr(`ROC_OFS_CTRL, 32'h1); wr(`ROC_OFS_CMD, 32'ha5c); w(3);
        `CHK("drive", 12'ha5c, relay_drive)
        rd(`ROC_OFS_ACTUAL); `CHK("actual", 32'ha5c, v)
        wr(`ROC_OFS_PREDEF, 32'h005); wr(`ROC_OFS_MASK, 32'h00f); w(3);
        `CHK("mask", 12'ha55, relay_drive)
        wr(`ROC_OFS_MASK, 32'h0); wr(`ROC_OFS_CTRL, 32'h5);
        wr(`ROC_OFS_CMD, 32'h0); w(3);
        `CHK("freeze", 12'ha5c, relay_drive)
        wr(`ROC_OFS_CTRL, 32'h9); wr(`ROC_OFS_TESTVAL, 32'h123); w(3);
        `CHK("test", 12'h123, relay_drive)
        // the flipped contact must wait out the settle time
        wr(`ROC_OFS_CTRL, 32'h1); flip <= 12'h800;
        wr(`ROC_OFS_CMD, 32'h801); w(2);
        rd(`ROC_OFS_MISMATCH); `CHK("early", 32'h0, v)
        w(25); rd(`ROC_OFS_MISMATCH); `CHK("mism", 32'h800, v)
        wr(`ROC_OFS_IRQ_MASK, 32'h1); w(1); `CHK("irq", 1'b1, irq)
        wr(`ROC_OFS_IRQ_MASK, 32'h0); w(2); `CHK("irqm", 1'b0, irq)
        flip <= 12'h000; w(4); wr(`ROC_OFS_IRQ_STAT, 32'hf);
        rd(`ROC_OFS_IRQ_STAT); `CHK("w1c", 32'h0, v)
        for (i = 0; i < 5; i++) begin
            sel_sw1 <= tbl[i][3]; sel_sw2 <= tbl[i][2];
            sup <= 0; flip <= 12'h001;
            wr(`ROC_OFS_CTRL, {tbl[i][1], 4'h1}); w(5);
            ex = tbl[i][0] ? 12'h000 : 12'h801;
            `CHK("inh", ex, relay_drive)
            rd(`ROC_OFS_INFO); `CHK("inhst", tbl[i][0], v[0])
            rd(`ROC_OFS_MISMATCH);
            if (tbl[i][0]) `CHK("inhmis", 32'h0, v)
        end
        sup <= 1; flip <= 12'h000; w(4);
        rd(`ROC_OFS_IRQ_STAT); `CHK("inhirq", 1'b1, v[1])
        wr(`ROC_OFS_PREDEF, 32'h0a0); wr(`ROC_OFS_FAILSEL, 32'h0f0);
        wr(`ROC_OFS_CTRL, 32'h0); w(3);
        `CHK("stop", 12'h8a1, relay_drive)
        wr(`ROC_OFS_CTRL, 32'h1); wr(`ROC_OFS_CMD, 32'h000); w(60);
        `CHK("comm", 12'h0a0, relay_drive)
        wr(`ROC_OFS_CMD, 32'hfff); w(3); fault <= 1; w(5);
        `CHK("ee", 12'h000, relay_drive)
        `CHK("led", 1'b1, err_led)
        rd(`ROC_OFS_INFO); `CHK("fail", 1'b1, v[3])
        fault <= 0; latched_strap <= 1; w(6); fault <= 1; w(5);
        `CHK("ml", 12'hfff, relay_drive)
        fault <= 0; sup <= 0; sel_sw1 <= 0; sel_sw2 <= 0; w(5);
        `CHK("mlinh", 12'hfff, relay_drive)
        sup <= 1; sel_sw1 <= 1; sel_sw2 <= 1;
        wr(`ROC_OFS_CTRL, 32'h3); wr(`ROC_OFS_CMD, 32'h0); w(3);
        `CHK("sleep", 1'b1, low_power)
        `CHK("slhold", 12'hfff, relay_drive)
        // mid-run reset, then the startup reset of the latched relays
        rst <= 1; w(2); rst <= 0;
        rd(`ROC_OFS_CTRL); `CHK("rstctl", 32'h0, v)
        wr(`ROC_OFS_CTRL, 32'h20); wr(`ROC_OFS_PREDEF, 32'hfff);
        wr(`ROC_OFS_FAILSEL, 32'hfff); w(3);
        `CHK("strst", 12'h000, relay_drive)
        wr(`ROC_OFS_CTRL, 32'h21); wr(`ROC_OFS_CTRL, 32'h20); w(3);
        `CHK("strdone", 12'hfff, relay_drive)
        stop_test;
    end
endmodule
